//--- design/gpp_port_cfg.svh
// Purpose: constants of the pin-change port: register offsets, field positions, reset values
// Assumes: an 8-bit core I/O space with a 6-bit address
// Notes: definitions only
`ifndef GPP_PORT_CFG_SVH
`define GPP_PORT_CFG_SVH

// port register offsets in the core I/O space
`define GPP_OFS_INPUT_SAMPLE 6'h00
`define GPP_OFS_DIRECTION 6'h01
`define GPP_OFS_OUTPUT_LATCH 6'h02
`define GPP_OFS_PULLUP_ENABLE 6'h03
`define GPP_OFS_PORT_CONTROL 6'h04
`define GPP_OFS_MCU_CONTROL 6'h05
`define GPP_OFS_PC_MASK 6'h10
`define GPP_OFS_PC_FLAGS 6'h11
`define GPP_OFS_PC_CONTROL 6'h12

// field positions
`define GPP_BIT_PC_GROUP_ENABLE 0
`define GPP_BIT_PC_FLAG 0
`define GPP_BIT_BBM_ENABLE 0
`define GPP_BIT_PULLUP_DISABLE 4
`define GPP_PC_MASK_BITS 4

// reset values
`define GPP_RST_BYTE 8'h00
`define GPP_RST_BIT 1'b0

`endif

//--- design/gpp_port_pkg.sv
// Purpose: types shared by the pin-change port
// Assumes: gpp_port_cfg.svh holds the numbers
// Notes: the request struct carries one core I/O access per cycle
package gpp_port_pkg;

  // one core I/O access: full write, single-bit set or clear, or read
  typedef struct packed {
    logic we;
    logic bset;
    logic bclr;
    logic re;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [2:0] bitSel;
  } gpp_io_req_s;

endpackage

//--- design/gpp_port.sv
// Purpose: general-purpose port with direction, latch, pull-up, toggle and pin-change flag
// Assumes: one system clock, synchronous active-low reset, core drives one access per cycle
// Notes: pins resolve outside from pinOut/pinOe/pinPull; pinIn is the pad level
//
// Notes on behaviour
// R1: group enable plus core enable lets any masked pin change raise the request.
// R2: any enabled change on the four pin-change inputs sets the sticky flag.
// R3: flag, group enable and core enable together send the core to the vector.
// R4: entering the routine clears the flag; writing one clears it, zero keeps it.
// R5: mask bits 3 to 0 enable detection per pin; cleared bit disables it.
// R6: change detection runs on the system clock, not the gated I/O clock.
// R7: bit set or clear alters only the addressed bit of a port register.
// R8: latch, direction, pull-up and sample registers; sample is read only.
// R9: writing one to a sample bit inverts that latch bit; zero does nothing.
// R10: global pull-up disable turns off every pull-up.
// R11: direction one drives the latch bit out; zero tri-states the pin.
// R12: pull-up follows its enable bit in both directions; output drives regardless.
// R13: reset tri-states every pin.
// R14: break-before-make holds the pin tri-stated one cycle on input-to-output.
// R15: one port-level bit selects break-before-make for all pins.
// R16: output-to-input releases the driver at once, in any mode.
// R17: software toggles a direction bit no faster than every two cycles.
// R18: the sample bit reads back in either direction.
// R19: input passes a falling-edge latch then a rising-edge register.
// R20: software waits one cycle between writing the latch and reading it back.
// R21: alternate use of some pins leaves the others working as plain I/O.
// R22: latch, direction and pull-up enables reset to zero.
`timescale 1ns/1ps
`include "gpp_port_cfg.svh"

module gpp_port #(
  parameter int PIN_COUNT = 4
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input gpp_port_pkg::gpp_io_req_s ioReq,
  output logic [7:0] ioRdData,
  input wire logic coreIntEnable,
  input wire logic vectorAck,
  output logic pinChangeVector,
  input wire logic [PIN_COUNT-1:0] pinIn,
  output logic [PIN_COUNT-1:0] pinOut,
  output logic [PIN_COUNT-1:0] pinOe,
  output logic [PIN_COUNT-1:0] pinPull
);
  import gpp_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // new register value after a full write or a single-bit set/clear at this offset
  function automatic logic [7:0] gppApply(input logic [7:0] cur, input gpp_io_req_s r,
                                          input logic [5:0] ofs);
    logic [7:0] v;
    v = cur;
    if (r.addr == ofs) begin
      if (r.we) begin
        v = r.wdata;
      end else if (r.bset) begin
        v[r.bitSel] = 1'b1;
      end else if (r.bclr) begin
        v[r.bitSel] = 1'b0;
      end
    end
    return v;
  endfunction

  // bits written as one at this offset; clears and zero bits give nothing
  function automatic logic [7:0] gppOnes(input gpp_io_req_s r, input logic [5:0] ofs);
    logic [7:0] v;
    v = `GPP_RST_BYTE;
    if (r.addr == ofs) begin
      if (r.we) begin
        v = r.wdata;
      end else if (r.bset) begin
        v[r.bitSel] = 1'b1;
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [PIN_COUNT-1:0] outLatch_q, outLatch_d;
  logic [PIN_COUNT-1:0] dir_q, dir_d;
  logic [PIN_COUNT-1:0] dirPrev_q;
  logic [PIN_COUNT-1:0] pue_q, pue_d;
  logic [PIN_COUNT-1:0] syncLatch_q;
  logic [PIN_COUNT-1:0] sample_q;
  logic [PIN_COUNT-1:0] samplePrev_q;
  logic [`GPP_PC_MASK_BITS-1:0] mask_q, mask_d;
  logic grpEn_q, grpEn_d;
  logic flag_q, flag_d;
  logic bbm_q, bbm_d;
  logic pud_q, pud_d;
  logic [7:0] rdData_q, rdData_d;
  logic irq_q;
  logic [PIN_COUNT-1:0] pinOut_q, pinOe_q, pinPull_q;
  logic [PIN_COUNT-1:0] oe_d;

  ////////////////////////////////////////////////////////////////////////////////
  // register writes

  wire [7:0] dirByte = gppApply(8'(dir_q), ioReq, `GPP_OFS_DIRECTION);
  wire [7:0] outByte = gppApply(8'(outLatch_q), ioReq, `GPP_OFS_OUTPUT_LATCH);
  wire [7:0] pueByte = gppApply(8'(pue_q), ioReq, `GPP_OFS_PULLUP_ENABLE);
  wire [7:0] maskByte = gppApply(8'(mask_q), ioReq, `GPP_OFS_PC_MASK);
  wire [7:0] ctlByte = gppApply({7'h00, grpEn_q} << `GPP_BIT_PC_GROUP_ENABLE, ioReq,
                                `GPP_OFS_PC_CONTROL);
  wire [7:0] portCtlByte = gppApply({7'h00, bbm_q} << `GPP_BIT_BBM_ENABLE, ioReq,
                                    `GPP_OFS_PORT_CONTROL);
  wire [7:0] mcuByte = gppApply({7'h00, pud_q} << `GPP_BIT_PULLUP_DISABLE, ioReq,
                                `GPP_OFS_MCU_CONTROL);
  // the sample location stores nothing; ones written there become toggles
  wire [7:0] toggleByte = gppOnes(ioReq, `GPP_OFS_INPUT_SAMPLE);
  wire [7:0] flagOnes = gppOnes(ioReq, `GPP_OFS_PC_FLAGS);

  // R7: single-bit access
  // every gppApply byte above is rebuilt from its own old value, so one bit moves
  assign dir_d = dirByte[PIN_COUNT-1:0];
  assign pue_d = pueByte[PIN_COUNT-1:0];
  assign mask_d = maskByte[`GPP_PC_MASK_BITS-1:0];
  assign grpEn_d = ctlByte[`GPP_BIT_PC_GROUP_ENABLE];
  assign bbm_d = portCtlByte[`GPP_BIT_BBM_ENABLE];
  assign pud_d = mcuByte[`GPP_BIT_PULLUP_DISABLE];

  // R9: toggle through sample location
  // direction plays no part, so an input pin's latch toggles as well
  assign outLatch_d = outByte[PIN_COUNT-1:0] ^ toggleByte[PIN_COUNT-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // input synchroniser

  // R19: falling-edge latch stage
  // catching on the low edge saves half a cycle against two rising-edge flops
  always_ff @(negedge ref_clk) begin
    if (!rstn) begin
      syncLatch_q <= '0;
    end else begin
      syncLatch_q <= pinIn;
    end
  end

  // R19: rising-edge sample register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sample_q <= '0;
      samplePrev_q <= '0;
    end else begin
      sample_q <= syncLatch_q;
      samplePrev_q <= sample_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin-change detection

  // R5: per-pin mask with group gate
  // R6: runs on the free system clock
  // pins driven as outputs still count, which lets software raise the request itself
  wire [`GPP_PC_MASK_BITS-1:0] pcEdges = `GPP_PC_MASK_BITS'(sample_q ^ samplePrev_q);
  wire [`GPP_PC_MASK_BITS-1:0] pcHits = pcEdges & mask_q;
  wire pcChange = grpEn_q & |pcHits;

  // R4: clear by vector entry or written one
  wire flagClear = vectorAck | flagOnes[`GPP_BIT_PC_FLAG];

  // R2: sticky flag, set wins over clear
  assign flag_d = pcChange | (flag_q & ~flagClear);

  ////////////////////////////////////////////////////////////////////////////////
  // pin drive

  // R11: direction selects driver
  // R14: break-before-make gap
  // R15: one enable for the whole port
  // R16: output-to-input needs no gap
  // R21: each pin uses only its own bits
  // a rising direction bit is held off one more cycle when the mode is on
  assign oe_d = dir_q & ~({PIN_COUNT{bbm_q}} & ~dirPrev_q);

  // R8: read-back mux
  // R18: sample reads back in any direction
  always_comb begin
    rdData_d = rdData_q;
    if (ioReq.re) begin
      unique case (ioReq.addr)
        `GPP_OFS_INPUT_SAMPLE: rdData_d = 8'(sample_q);
        `GPP_OFS_DIRECTION: rdData_d = 8'(dir_q);
        `GPP_OFS_OUTPUT_LATCH: rdData_d = 8'(outLatch_q);
        `GPP_OFS_PULLUP_ENABLE: rdData_d = 8'(pue_q);
        `GPP_OFS_PORT_CONTROL: rdData_d = 8'(bbm_q) << `GPP_BIT_BBM_ENABLE;
        `GPP_OFS_MCU_CONTROL: rdData_d = 8'(pud_q) << `GPP_BIT_PULLUP_DISABLE;
        `GPP_OFS_PC_MASK: rdData_d = 8'(mask_q);
        `GPP_OFS_PC_FLAGS: rdData_d = 8'(flag_q) << `GPP_BIT_PC_FLAG;
        `GPP_OFS_PC_CONTROL: rdData_d = 8'(grpEn_q) << `GPP_BIT_PC_GROUP_ENABLE;
        default: rdData_d = `GPP_RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state update

  // R22: control registers reset to zero
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      outLatch_q <= '0;
      dir_q <= '0;
      dirPrev_q <= '0;
      pue_q <= '0;
      mask_q <= '0;
      grpEn_q <= `GPP_RST_BIT;
      flag_q <= `GPP_RST_BIT;
      bbm_q <= `GPP_RST_BIT;
      pud_q <= `GPP_RST_BIT;
      rdData_q <= `GPP_RST_BYTE;
    end else begin
      outLatch_q <= outLatch_d;
      dir_q <= dir_d;
      dirPrev_q <= dir_q;
      pue_q <= pue_d;
      mask_q <= mask_d;
      grpEn_q <= grpEn_d;
      flag_q <= flag_d;
      bbm_q <= bbm_d;
      pud_q <= pud_d;
      rdData_q <= rdData_d;
    end
  end

  // R13: reset tri-states pins
  // R10: global pull-up disable
  // R12: pull-up independent of direction
  // R1: request gate
  // R3: vector request
  // reset is synchronous here, so the pins float from the first clocked reset edge
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pinOut_q <= '0;
      pinOe_q <= '0;
      pinPull_q <= '0;
      irq_q <= `GPP_RST_BIT;
    end else begin
      pinOut_q <= outLatch_q;
      pinOe_q <= oe_d;
      pinPull_q <= pue_q & ~{PIN_COUNT{pud_q}};
      irq_q <= flag_d & grpEn_d & coreIntEnable;
    end
  end

  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign pinPull = pinPull_q;
  assign ioRdData = rdData_q;
  assign pinChangeVector = irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_vectorGate;
    @(posedge ref_clk) disable iff (!rstn)
      pinChangeVector |-> flag_q && grpEn_q && $past(coreIntEnable);
  endproperty
  a_vectorGate: assert property (p_vectorGate) else $error("vector without flag and enables"); // R3

  property p_flagSets;
    @(posedge ref_clk) disable iff (!rstn)
      pcChange |=> flag_q;
  endproperty
  a_flagSets: assert property (p_flagSets) else $error("enabled change did not set flag"); // R2

  property p_flagCause;
    @(posedge ref_clk) disable iff (!rstn)
      $rose(flag_q) |-> $past(grpEn_q) && ($past(pcHits) != '0);
  endproperty
  a_flagCause: assert property (p_flagCause) else $error("flag set without masked change"); // R5

  property p_ackClears;
    @(posedge ref_clk) disable iff (!rstn)
      flag_q && vectorAck && !pcChange |=> !flag_q;
  endproperty
  a_ackClears: assert property (p_ackClears) else $error("vector entry left flag set"); // R4

  property p_toggle;
    @(posedge ref_clk) disable iff (!rstn)
      ioReq.we && ioReq.addr == `GPP_OFS_INPUT_SAMPLE && ioReq.wdata[0]
        |=> outLatch_q[0] != $past(outLatch_q[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("written one did not toggle latch"); // R9

  property p_bbmGap;
    @(posedge ref_clk) disable iff (!rstn)
      bbm_q && dir_q[0] && !dirPrev_q[0] |=> !pinOe[0] ##1 (pinOe[0] || !$past(dir_q[0]));
  endproperty
  a_bbmGap: assert property (p_bbmGap) else $error("break-before-make gap wrong"); // R14

  property p_noGap;
    @(posedge ref_clk) disable iff (!rstn)
      !bbm_q && dir_q[0] |=> pinOe[0] && pinOut[0] == $past(outLatch_q[0]);
  endproperty
  a_noGap: assert property (p_noGap) else $error("output not driven from latch"); // R11

  property p_release;
    @(posedge ref_clk) disable iff (!rstn)
      !dir_q[0] |=> !pinOe[0];
  endproperty
  a_release: assert property (p_release) else $error("driver not released at once"); // R16

  property p_pullOff;
    @(posedge ref_clk) disable iff (!rstn)
      pud_q |=> pinPull == '0;
  endproperty
  a_pullOff: assert property (p_pullOff) else $error("pull-up on while disabled"); // R10

  property p_resetState;
    @(posedge ref_clk)
      !rstn |=> pinOe == '0 && dir_q == '0 && outLatch_q == '0 && pue_q == '0;
  endproperty
  a_resetState: assert property (p_resetState) else $error("reset left pins or regs set"); // R13

endmodule // gpp_port

//--- tb/gpp_pin_model.sv
// Purpose: pad model that works out each pin from device drive, external source and pull-up
// Assumes: extEn picks an external source per pin; the device driver wins over it
// Notes: an undriven pin without pull-up flips every cycle, so a stale level never reads back
`timescale 1ns/1ps
module gpp_pin_model (
  input wire logic ref_clk,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  input wire logic [3:0] pinPull,
  input wire logic [3:0] extEn,
  input wire logic [3:0] extVal,
  output logic [3:0] pinIn
);
  logic [3:0] floatLvl_q = 4'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // floating level keeps moving
  always @(posedge ref_clk) begin
    floatLvl_q <= ~floatLvl_q;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : extEn[i] ? extVal[i] : pinPull[i] ? 1'b1 : floatLvl_q[i];
    end
  end
endmodule // gpp_pin_model

//--- tb/tb_gpp_port.sv
// Purpose: self-checking bench of the pin-change port
// Assumes: offsets and fields of gpp_port_cfg.svh; read data is due one cycle after the read
// Notes: reads queue their expected byte and a monitor compares when the data is due
`timescale 1ns/1ps
`include "gpp_port_cfg.svh"
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module tb_gpp_port;
  import gpp_port_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  gpp_io_req_s ioReq = '0;
  logic [7:0] ioRdData;
  logic coreIntEnable = 1'b0;
  logic vectorAck = 1'b0;
  logic pinChangeVector;
  logic [3:0] pinIn, pinOut, pinOe, pinPull;
  logic [3:0] extVal = 4'h0;
  logic [3:0] extEn = 4'hF;
  logic [3:0] lat;
  logic [7:0] expQ[$];
  logic [7:0] expRd;
  logic [7:0] r;
  logic rdPend = 1'b0;
  int errors = 0;
  int testsRun = 0;
  int seed = 17;
  ////////////////////////////////////////////////////////////////////////////////
  always #20 ref_clk = ~ref_clk;
  gpp_port #(.PIN_COUNT(4)) u_gpp_port (.ref_clk(ref_clk), .rstn(rstn), .ioReq(ioReq),
    .ioRdData(ioRdData), .coreIntEnable(coreIntEnable), .vectorAck(vectorAck),
    .pinChangeVector(pinChangeVector), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pinPull(pinPull));
  gpp_pin_model u_gpp_pin_model (.ref_clk(ref_clk), .pinOut(pinOut), .pinOe(pinOe),
    .pinPull(pinPull), .extEn(extEn), .extVal(extVal), .pinIn(pinIn));
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: read data is compared in the cycle after the read edge
  always @(posedge ref_clk) begin
    if (rdPend) begin
      expRd = expQ.pop_front();
      `CHK("read data", expRd, ioRdData)
    end
    rdPend <= ioReq.re;
  end
  // one access, held for exactly one taking edge
  task automatic io(input logic w, s, c, rd, input logic [5:0] a, input logic [7:0] d,
      input logic [2:0] b);
    @(posedge ref_clk);
    ioReq <= '{we: w, bset: s, bclr: c, re: rd, addr: a, wdata: d, bitSel: b};
    @(posedge ref_clk);
    ioReq <= '0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io(1'b1, 1'b0, 1'b0, 1'b0, a, d, 3'h0);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    expQ.push_back(e);
    io(1'b0, 1'b0, 1'b0, 1'b1, a, 8'h00, 3'h0);
  endtask
  // wait edges, then let their updates land
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic flip(input logic [3:0] p);
    @(posedge ref_clk);
    extVal <= extVal ^ p;
    settle(6);
  endtask
  task automatic end_sim();
    if (errors == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog sized well above the whole sequence
  initial begin
    #400000;
    errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    `CHK("oe", 4'h0, pinOe)
    `CHK("pull", 4'h0, pinPull)
    `CHK("vector", 1'b0, pinChangeVector)
    rd(`GPP_OFS_DIRECTION, 8'h00);
    rd(`GPP_OFS_OUTPUT_LATCH, 8'h00);
    rd(`GPP_OFS_PULLUP_ENABLE, 8'h00);
    rd(`GPP_OFS_PC_MASK, 8'h00);
    rd(`GPP_OFS_PC_FLAGS, 8'h00);
    rd(6'h3F, 8'h00);
    // latch write and toggle through the sample place
    for (int k = 0; k < 4; k++) begin
      r = 8'($random(seed));
      wr(`GPP_OFS_OUTPUT_LATCH, r);
      rd(`GPP_OFS_OUTPUT_LATCH, {4'h0, r[3:0]});
      wr(`GPP_OFS_INPUT_SAMPLE, {4'h0, r[7:4]});
      lat = r[3:0] ^ r[7:4];
      rd(`GPP_OFS_OUTPUT_LATCH, {4'h0, lat});
    end
    wr(`GPP_OFS_PULLUP_ENABLE, 8'h05);
    for (int b = 0; b < 4; b++) begin
      io(1'b0, 1'b1, 1'b0, 1'b0, `GPP_OFS_PULLUP_ENABLE, 8'h00, b[2:0]);
      rd(`GPP_OFS_PULLUP_ENABLE, 8'h05 | (8'h01 << b));
      io(1'b0, 1'b0, 1'b1, 1'b0, `GPP_OFS_PULLUP_ENABLE, 8'h00, b[2:0]);
      rd(`GPP_OFS_PULLUP_ENABLE, 8'h05 & ~(8'h01 << b));
      wr(`GPP_OFS_PULLUP_ENABLE, 8'h05);
    end
    settle(2);
    `CHK("pull", 4'h5, pinPull)
    wr(`GPP_OFS_MCU_CONTROL, 8'h10);
    settle(2);
    `CHK("pull", 4'h0, pinPull)
    wr(`GPP_OFS_MCU_CONTROL, 8'h00);
    // pulled inputs read high once the outside lets go of them
    extEn <= 4'hA;
    settle(3);
    rd(`GPP_OFS_INPUT_SAMPLE, 8'h05);
    extEn <= 4'hF;
    for (int m = 0; m < 2; m++) begin
      wr(`GPP_OFS_PORT_CONTROL, {7'h00, m[0]});
      wr(`GPP_OFS_DIRECTION, 8'h0F);
      settle(1);
      `CHK("oe early", m[0] ? 4'h0 : 4'hF, pinOe)
      settle(1);
      `CHK("oe", 4'hF, pinOe)
      `CHK("out", lat, pinOut)
      `CHK("pull", 4'h5, pinPull)
      // driven pin level read back through the sample location only after idle cycles
      rd(`GPP_OFS_INPUT_SAMPLE, {4'h0, lat});
      wr(`GPP_OFS_DIRECTION, 8'h00);
      settle(1);
      `CHK("oe off", 4'h0, pinOe)
    end
    // reset in mid-run while the port drives
    wr(`GPP_OFS_DIRECTION, 8'h0F);
    settle(2);
    `CHK("oe before reset", 4'hF, pinOe)
    @(posedge ref_clk);
    rstn <= 1'b0;
    @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    `CHK("oe in reset", 4'h0, pinOe)
    `CHK("pull in reset", 4'h0, pinPull)
    rd(`GPP_OFS_DIRECTION, 8'h00);
    r = 8'($random(seed));
    @(posedge ref_clk);
    extVal <= r[3:0];
    rd(`GPP_OFS_INPUT_SAMPLE, {4'h0, r[3:0]});
    wr(`GPP_OFS_PC_MASK, 8'h01);
    wr(`GPP_OFS_PC_CONTROL, 8'h01);
    coreIntEnable <= 1'b1;
    flip(4'h2);
    `CHK("vector", 1'b0, pinChangeVector)
    rd(`GPP_OFS_PC_FLAGS, 8'h00);
    flip(4'h1);
    `CHK("vector", 1'b1, pinChangeVector)
    rd(`GPP_OFS_PC_FLAGS, 8'h01);
    wr(`GPP_OFS_PC_FLAGS, 8'h00);
    rd(`GPP_OFS_PC_FLAGS, 8'h01);
    @(posedge ref_clk);
    vectorAck <= 1'b1;
    @(posedge ref_clk);
    vectorAck <= 1'b0;
    settle(2);
    `CHK("vector", 1'b0, pinChangeVector)
    rd(`GPP_OFS_PC_FLAGS, 8'h00);
    // flag without core enable, cleared by writing one
    @(posedge ref_clk);
    coreIntEnable <= 1'b0;
    flip(4'h1);
    `CHK("vector", 1'b0, pinChangeVector)
    rd(`GPP_OFS_PC_FLAGS, 8'h01);
    wr(`GPP_OFS_PC_FLAGS, 8'h01);
    rd(`GPP_OFS_PC_FLAGS, 8'h00);
    wr(`GPP_OFS_PC_CONTROL, 8'h00);
    coreIntEnable <= 1'b1;
    flip(4'h1);
    `CHK("vector", 1'b0, pinChangeVector)
    rd(`GPP_OFS_PC_FLAGS, 8'h00);
    settle(2);
    end_sim();
  end
endmodule // tb_gpp_port
